// file: src/fault_alert_defines.vh
`ifndef FAULT_ALERT_DEFINES_VH
`define FAULT_ALERT_DEFINES_VH
`define ALERT_MASK_ADDR 8'hf9
`define FAULT_MASK_ADDR 8'hfa
`define GEN_FLAGS_ADDR 8'hfb
`define PHASE_FLAGS_ADDR 8'hfc
`define MASK_RESET 8'h00
`define MASK_VOUT_BIT 7
`define MASK_IOUT_BIT 6
`define MASK_COMM_LOGIC_BIT 3
`define MASK_MON_VOLT_BIT 2
`define MASK_POUT_BIT 0
`define MASK_WRITABLE 8'hcd
`define GEN_FAULT_BIT 7
`define GEN_ALERT_BIT 6
`define GEN_PGOOD_BIT 5
`define GEN_READY_BIT 4
`define PH4_BIT 5
`define PH3_BIT 4
`define PH2_BIT 3
`define POWER_SAVE_BIT 2
`define RDATA_IDLE 8'h00
`endif

// file: src/input_sync.v
`timescale 1ns/100ps
module input_sync (
   input wire mclk_i,
   input wire rst_i,
   input wire [11:0] async_i,
   output wire [11:0] sync_o
);
   reg [11:0] meta_ff;
   reg [11:0] sync_ff;
   genvar gi;
   generate
      for (gi = 0; gi < 12; gi = gi + 1) begin : g_bit
         always @(posedge mclk_i) begin
            if (rst_i) begin
               meta_ff[gi] <= 1'b0;
               sync_ff[gi] <= 1'b0;
            end else begin
               meta_ff[gi] <= async_i[gi];
               sync_ff[gi] <= meta_ff[gi];
            end
         end
      end
   endgenerate
   assign sync_o = sync_ff;
endmodule // input_sync

// file: src/fault_alert_mask_status_regs.v
// Behaviour
// - alert mask bit 3 blocks alerts from comm/memory/logic status.
// - bit 2 of both masks blocks monitored voltage limit signalling.
// - alert mask bit 0 blocks alerts from output power over limit.
// - fault mask bits 7 and 6 block output voltage and current faults.
// - fault mask bit 3 blocks faults from comm/memory/logic status.
// - fault mask bit 0 blocks power faults; bits 5,4,1 reserved.
// - general status bit 5 power-good is superseded, host uses status word.
// - phase status bits 5,4,3 show phases 4,3,2 enabled.
// - phase status bit 2 follows the power save indicator.
`timescale 1ns/100ps
`include "fault_alert_defines.vh"
module fault_alert_mask_status_regs (
   input wire mclk_i,
   input wire rst_i,
   input wire reg_wr_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   output wire [7:0] reg_rdata_o,
   output wire reg_hit_o,
   input wire vout_status_i,
   input wire iout_status_i,
   input wire comm_logic_status_i,
   input wire monitored_voltage_input_hi_i,
   input wire monitored_voltage_input_lo_i,
   input wire pout_status_i,
   input wire power_good_i,
   input wire ready_i,
   input wire [2:0] phase_en_i,
   input wire power_save_indicator_i,
   output wire alert_o,
   output wire fault_o
);
   reg [7:0] alert_mask_ff;
   reg [7:0] fault_source_mask_ff;
   reg [7:0] nxt_alert_mask;
   reg [7:0] nxt_fault_mask;
   reg alert_ff;
   reg fault_ff;
   reg [7:0] rdata_ff;
   reg [7:0] nxt_rdata;
   wire [11:0] pin_raw;
   wire [11:0] pin_sync;
   wire vout_s;
   wire iout_s;
   wire comm_s;
   wire mon_hi_s;
   wire mon_lo_s;
   wire pout_s;
   wire pgood_s;
   wire ready_s;
   wire [2:0] phase_s;
   wire save_s;
   wire [5:0] src_w;
   wire [5:0] alert_block;
   wire [5:0] fault_block;
   wire [5:0] alert_hit;
   wire [5:0] fault_hit;
   wire nxt_alert;
   wire nxt_fault;
   wire hit_alert_mask;
   wire hit_fault_mask;
   wire hit_gen_flags;
   wire hit_phase_flags;
   wire wr_alert_mask;
   wire wr_fault_mask;
   wire [7:0] gen_flags;
   wire [7:0] phase_flags;
   genvar gi;

   // every pin level crosses two flops before any logic sees it
   assign pin_raw[0] = vout_status_i;
   assign pin_raw[1] = iout_status_i;
   assign pin_raw[2] = comm_logic_status_i;
   assign pin_raw[3] = monitored_voltage_input_hi_i;
   assign pin_raw[4] = monitored_voltage_input_lo_i;
   assign pin_raw[5] = pout_status_i;
   assign pin_raw[6] = power_good_i;
   assign pin_raw[7] = ready_i;
   assign pin_raw[8] = phase_en_i[0];
   assign pin_raw[9] = phase_en_i[1];
   assign pin_raw[10] = phase_en_i[2];
   assign pin_raw[11] = power_save_indicator_i;

   input_sync u_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .async_i(pin_raw),
      .sync_o(pin_sync)
   );

   assign vout_s = pin_sync[0];
   assign iout_s = pin_sync[1];
   assign comm_s = pin_sync[2];
   assign mon_hi_s = pin_sync[3];
   assign mon_lo_s = pin_sync[4];
   assign pout_s = pin_sync[5];
   assign pgood_s = pin_sync[6];
   assign ready_s = pin_sync[7];
   assign phase_s = pin_sync[10:8];
   assign save_s = pin_sync[11];

   // one decoded hit per register, shared by write strobe and bus hit
   assign hit_alert_mask = (reg_addr_i == `ALERT_MASK_ADDR);
   assign hit_fault_mask = (reg_addr_i == `FAULT_MASK_ADDR);
   assign hit_gen_flags = (reg_addr_i == `GEN_FLAGS_ADDR);
   assign hit_phase_flags = (reg_addr_i == `PHASE_FLAGS_ADDR);
   assign reg_hit_o = hit_alert_mask | hit_fault_mask | hit_gen_flags |
      hit_phase_flags;
   // status registers have no write path at all
   assign wr_alert_mask = reg_wr_i & hit_alert_mask;
   assign wr_fault_mask = reg_wr_i & hit_fault_mask;

   // reserved mask bits never store a one
   always @* begin
      nxt_alert_mask = alert_mask_ff;
      nxt_fault_mask = fault_source_mask_ff;
      if (wr_alert_mask) begin
         nxt_alert_mask = reg_wdata_i & `MASK_WRITABLE;
      end
      if (wr_fault_mask) begin
         nxt_fault_mask = reg_wdata_i & `MASK_WRITABLE;
      end
   end

   always @(posedge mclk_i) begin
      if (rst_i) begin
         alert_mask_ff <= `MASK_RESET;
         fault_source_mask_ff <= `MASK_RESET;
      end else begin
         alert_mask_ff <= nxt_alert_mask;
         fault_source_mask_ff <= nxt_fault_mask;
      end
   end

   // both limit crossings of the monitored voltage share one mask bit
   assign src_w[0] = vout_s;
   assign src_w[1] = iout_s;
   assign src_w[2] = comm_s;
   assign src_w[3] = mon_hi_s;
   assign src_w[4] = mon_lo_s;
   assign src_w[5] = pout_s;

   assign alert_block[0] = alert_mask_ff[`MASK_VOUT_BIT];
   assign alert_block[1] = alert_mask_ff[`MASK_IOUT_BIT];
   assign alert_block[2] = alert_mask_ff[`MASK_COMM_LOGIC_BIT];
   assign alert_block[3] = alert_mask_ff[`MASK_MON_VOLT_BIT];
   assign alert_block[4] = alert_mask_ff[`MASK_MON_VOLT_BIT];
   assign alert_block[5] = alert_mask_ff[`MASK_POUT_BIT];
   assign fault_block[0] = fault_source_mask_ff[`MASK_VOUT_BIT];
   assign fault_block[1] = fault_source_mask_ff[`MASK_IOUT_BIT];
   assign fault_block[2] = fault_source_mask_ff[`MASK_COMM_LOGIC_BIT];
   assign fault_block[3] = fault_source_mask_ff[`MASK_MON_VOLT_BIT];
   assign fault_block[4] = fault_source_mask_ff[`MASK_MON_VOLT_BIT];
   assign fault_block[5] = fault_source_mask_ff[`MASK_POUT_BIT];

   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_src
         assign alert_hit[gi] = src_w[gi] & ~alert_block[gi];
         assign fault_hit[gi] = src_w[gi] & ~fault_block[gi];
      end
   endgenerate
   assign nxt_alert = |alert_hit;
   assign nxt_fault = |fault_hit;

   always @(posedge mclk_i) begin
      if (rst_i) begin
         alert_ff <= 1'b0;
         fault_ff <= 1'b0;
      end else begin
         alert_ff <= nxt_alert;
         fault_ff <= nxt_fault;
      end
   end
   assign alert_o = alert_ff;
   assign fault_o = fault_ff;

   assign gen_flags[`GEN_FAULT_BIT] = fault_ff;
   assign gen_flags[`GEN_ALERT_BIT] = alert_ff;
   // legacy power-good copy; the status word holds the live one
   assign gen_flags[`GEN_PGOOD_BIT] = pgood_s;
   assign gen_flags[`GEN_READY_BIT] = ready_s;
   assign gen_flags[3:0] = 4'h0;

   assign phase_flags[7:6] = 2'h0;
   assign phase_flags[`PH4_BIT] = phase_s[2];
   assign phase_flags[`PH3_BIT] = phase_s[1];
   assign phase_flags[`PH2_BIT] = phase_s[0];
   assign phase_flags[`POWER_SAVE_BIT] = save_s;
   assign phase_flags[1:0] = 2'h0;

   // unmapped addresses read back as zero
   always @* begin
      case (reg_addr_i)
         `ALERT_MASK_ADDR: begin
            nxt_rdata = alert_mask_ff;
         end
         `FAULT_MASK_ADDR: begin
            nxt_rdata = fault_source_mask_ff;
         end
         `GEN_FLAGS_ADDR: begin
            nxt_rdata = gen_flags;
         end
         `PHASE_FLAGS_ADDR: begin
            nxt_rdata = phase_flags;
         end
         default: begin
            nxt_rdata = `RDATA_IDLE;
         end
      endcase
   end

   always @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_ff <= `RDATA_IDLE;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end
   assign reg_rdata_o = rdata_ff;
endmodule // fault_alert_mask_status_regs

// file: testbench/regs_mon_monitor.sv
`timescale 1ns/100ps
module regs_mon (
   input wire mclk_i,
   input wire rst_i,
   input wire reg_wr_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire [7:0] reg_rdata_o,
   input wire reg_hit_o,
   input wire alert_o,
   input wire fault_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   a_hit_decode: assert property (reg_hit_o ==
      (reg_addr_i >= 8'hf9 && reg_addr_i <= 8'hfc)) else $error("bad hit");
   a_unmapped_zero: assert property (!$past(reg_hit_o) |->
      reg_rdata_o == 8'h00) else $error("unmapped not zero");
   a_mask_reserved: assert property ($past(reg_addr_i) >= 8'hf9 &&
      $past(reg_addr_i) <= 8'hfa |-> (reg_rdata_o & 8'h32) == 8'h00)
      else $error("reserved mask bit set");
   a_phase_spare: assert property ($past(reg_addr_i) == 8'hfc |->
      (reg_rdata_o & 8'hc3) == 8'h00) else $error("phase spare bit set");
   a_gen_low: assert property ($past(reg_addr_i) == 8'hfb |->
      reg_rdata_o[3:0] == 4'h0) else $error("general low bits set");
   a_mask_write: assert property (reg_wr_i && reg_addr_i == 8'hfa ##1
      !reg_wr_i && reg_addr_i == 8'hfa |=> reg_rdata_o ==
      ($past(reg_wdata_i, 2) & 8'hcd)) else $error("mask write lost");
   a_gen_mirror: assert property ($past(reg_addr_i) == 8'hfb |->
      reg_rdata_o[7:6] == {$past(fault_o), $past(alert_o)})
      else $error("general flags stale");
   c_write: cover property (reg_wr_i && reg_addr_i == 8'hfa);
   c_psi: cover property ($past(reg_addr_i) == 8'hfc && reg_rdata_o[2]);
   c_hit: cover property (!reg_hit_o ##1 reg_hit_o);
   c_alert_only: cover property (alert_o && !fault_o);
   c_fault_only: cover property (fault_o && !alert_o);
endmodule // regs_mon

// file: testbench/pmbus_host.sv
`timescale 1ns/100ps
module pmbus_host (
   input wire c_i,
   input wire [7:0] rd_i,
   output reg w_o = 1'b0,
   output reg [7:0] a_o = 8'h00,
   output reg [7:0] d_o = 8'h00
);
   task put(input [7:0] a, input [7:0] d); begin
      @(posedge c_i);
      a_o <= a;
      d_o <= d;
      w_o <= 1'b1;
      @(posedge c_i);
      w_o <= 1'b0;
      d_o <= ~d;
   end endtask
   task get(input [7:0] a, output [7:0] d); begin
      @(posedge c_i);
      a_o <= a;
      @(posedge c_i);
      @(posedge c_i);
      d = rd_i;
   end endtask
endmodule // pmbus_host

// file: testbench/fault_alert_mask_status_regs_tb.sv
`timescale 1ns/100ps
module fault_alert_mask_status_regs_tb;
   reg mclk_i = 1'b0;
   reg rst_i = 1'b1;
   reg [5:0] s = 6'h00;
   reg [2:0] ph = 3'h0;
   reg power_save_indicator = 1'b0;
   reg rdy = 1'b0;
   reg pg = 1'b0;
   reg [31:0] rnd;
   wire w, hit, al, fl;
   wire [7:0] a, d, rd;
   integer n_errors = 0, cmp_count = 0, cyc = 0, i;
   reg [7:0] v, r;
   always #25 mclk_i = ~mclk_i;
   pmbus_host h (.c_i(mclk_i), .rd_i(rd), .w_o(w), .a_o(a), .d_o(d));
   fault_alert_mask_status_regs dut (.mclk_i(mclk_i), .rst_i(rst_i),
      .reg_wr_i(w), .reg_addr_i(a), .reg_wdata_i(d), .reg_rdata_o(rd),
      .reg_hit_o(hit), .vout_status_i(s[0]), .iout_status_i(s[1]),
      .comm_logic_status_i(s[2]), .monitored_voltage_input_hi_i(s[3]),
      .monitored_voltage_input_lo_i(s[4]), .pout_status_i(s[5]),
      .power_good_i(pg), .ready_i(rdy), .phase_en_i(ph),
      .power_save_indicator_i(power_save_indicator), .alert_o(al), .fault_o(fl));
   function [7:0] mb(input integer k);
      mb = 8'h01 << ((k > 2) ? ((k == 5) ? 0 : 2) : ((k == 2) ? 3 : 7 - k));
   endfunction
   task chk(input [8*5-1:0] n, input [7:0] sn, input [7:0] e); begin
      cmp_count = cmp_count + 1;
      if (sn !== e) begin
         n_errors = n_errors + 1;
         $display("wrong value %0s exp %h seen %h", n, e, sn);
      end
   end endtask
   task give_verdict; begin
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   end endtask
   task src(input [7:0] fm, input [7:0] am); begin
      h.put(8'hfa, fm);
      h.put(8'hf9, am);
      repeat (3) @(posedge mclk_i);
      #1;
   end endtask
   always @(posedge mclk_i) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         n_errors = n_errors + 1;
         give_verdict;
      end
   end
   initial begin
      rnd = $urandom(29);
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
         h.get(8'hf9 + i[7:0], r);
         chk("reset", r, 8'h00);
      end
      $display("reset tests done");
      for (i = 0; i < 10; i = i + 1) begin
         rnd = $urandom;
         v = (i < 2) ? 8'hff : rnd[7:0];
         h.put(8'hfa - i[0], v);
         h.get(8'hfa - i[0], r);
         chk("mask", r, v & 8'hcd);
      end
      for (i = 0; i < 8; i = i + 1) begin
         @(posedge mclk_i);
         rnd = $urandom;
         ph <= rnd[2:0];
         power_save_indicator <= i[0];
         h.put(8'hfc, 8'hff);
         h.get(8'hfc, r);
         chk("phase", r, {2'b00, ph, power_save_indicator, 2'b00});
      end
      $display("register tests done");
      rdy <= 1'b1;
      for (i = 0; i < 6; i = i + 1) begin
         s <= 6'h01 << i;
         pg <= i[0];
         src(8'h00, 8'h00);
         chk("fault", fl, 8'h01);
         chk("alert", al, 8'h01);
         h.get(8'hfb, r);
         chk("gen", r, {2'b11, pg, 5'h10});
         src(mb(i), 8'h00);
         chk("fmask", fl, 8'h00);
         chk("alert", al, 8'h01);
         src(8'h00, mb(i));
         chk("fault", fl, 8'h01);
         chk("amask", al, 8'h00);
         src(mb(i), mb(i));
         chk("fmask", fl, 8'h00);
         chk("amask", al, 8'h00);
      end
      $display("mask tests done");
      give_verdict;
   end
endmodule // fault_alert_mask_status_regs_tb
bind fault_alert_mask_status_regs regs_mon mon (.mclk_i(mclk_i),
   .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .reg_hit_o(reg_hit_o), .alert_o(alert_o), .fault_o(fault_o));
